// ==== rtl/timer_pair_pkg.sv ====
// Constants shared by the dual timer/counter unit
package timer_pair_pkg;

  // ==========================================================
  // Special-function addresses
  localparam logic [7:0] ADDR_RUN_OVF_CTRL = 8'h88;  // Run bits and overflow flags
  localparam logic [7:0] ADDR_MODE_CFG     = 8'h89;  // Mode nibbles for both timers
  localparam logic [7:0] ADDR_LOW_ZERO     = 8'h8a;  // Timer 0 low count byte
  localparam logic [7:0] ADDR_LOW_ONE      = 8'h8b;  // Timer 1 low count byte
  localparam logic [7:0] ADDR_HIGH_ZERO    = 8'h8c;  // Timer 0 high count byte
  localparam logic [7:0] ADDR_HIGH_ONE     = 8'h8d;  // Timer 1 high count byte

  // ==========================================================
  // Field positions in the control register
  localparam int unsigned BIT_OVF_ONE  = 7;  // Timer 1 overflow flag
  localparam int unsigned BIT_RUN_ONE  = 6;  // Timer 1 run bit
  localparam int unsigned BIT_OVF_ZERO = 5;  // Timer 0 overflow flag
  localparam int unsigned BIT_RUN_ZERO = 4;  // Timer 0 run bit

  // ==========================================================
  // Field positions in the mode register
  localparam int unsigned BIT_GATE_ONE  = 7;  // Timer 1 gating enable
  localparam int unsigned BIT_CT_ONE    = 6;  // Timer 1 counter select
  localparam int unsigned POS_MODE_ONE  = 4;  // Timer 1 mode field, two bits
  localparam int unsigned BIT_GATE_ZERO = 3;  // Timer 0 gating enable
  localparam int unsigned BIT_CT_ZERO   = 2;  // Timer 0 counter select
  localparam int unsigned POS_MODE_ZERO = 0;  // Timer 0 mode field, two bits

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_RUN_OVF_CTRL = 8'h00;  // Control register
  localparam logic [7:0] RST_MODE_CFG     = 8'h00;  // Mode register
  localparam logic [7:0] RST_COUNT        = 8'h00;  // Count bytes

  // ==========================================================
  // Machine cycle timing, counted in core clocks
  localparam logic [3:0] PHASES_PER_CYCLE = 4'hc;  // Twelve core clocks per cycle
  localparam logic [3:0] SAMPLE_PHASE     = 4'h9;  // State five, phase two
  localparam logic [3:0] UPDATE_PHASE     = 4'h4;  // State three, phase one
  localparam logic [4:0] PRESCALE_FULL    = 5'h1f; // Last prescaler count

  // ==========================================================
  // Timer modes, in the order of the two-bit field
  typedef enum logic [1:0] {
    MODE_13BIT,   // 8-bit count behind a 5-bit prescaler
    MODE_16BIT,   // Cascaded 16-bit count
    MODE_RELOAD,  // 8-bit count reloaded from the high byte
    MODE_SPLIT    // Stopped (timer 1) or split in two (timer 0)
  } mode_t;

endpackage

// ==== rtl/pin_edge_sampler.sv ====
// Pin synchroniser with machine-cycle sampling and falling edge detection
`timescale 1ns/100ps

module pin_edge_sampler (
  input  wire logic clk,        // Core clock
  input  wire logic rst,        // Asynchronous reset, active high
  input  wire logic pin,        // Raw pin, asynchronous to clk
  input  wire logic sample_en,  // High for the sample phase of each cycle
  output logic      level,      // Filtered pin level
  output logic      edge_seen   // Fall seen between the last two samples
);

  // ==========================================================
  // Synchroniser
  logic sync1_r;   // First stage, read only by the second stage
  logic sync2_r;   // Second stage
  logic sync3_r;   // Third stage
  logic stable_r;  // Level accepted once stages two and three agree
  logic smp_r;     // Level at the previous sample phase
  logic edge_r;    // Fall found at the latest sample phase

  // Three flops guard against metastability; agreement filters a single glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Accept a change only when the two late stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_r <= 1'b0;
    end else if (sync2_r == sync3_r) begin
      stable_r <= sync3_r;
    end
  end

  // ==========================================================
  // Once-per-cycle sampling
  // Sample starts low so a pin held high at reset gives no false fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smp_r  <= 1'b0;
      edge_r <= 1'b0;
    end else if (sample_en) begin
      smp_r  <= stable_r;
      edge_r <= smp_r & ~stable_r;
    end
  end

  assign level     = stable_r;
  assign edge_seen = edge_r;

endmodule

// ==== rtl/timer_pair.sv ====
// Dual 16-bit timer/counter unit with mode and control registers
`timescale 1ns/100ps

module timer_pair (
  input  wire logic       clk,                // Core clock, 50 MHz
  input  wire logic       rst,                // Asynchronous reset, active high
  input  wire logic [7:0] sfr_addr,           // Special-function address
  input  wire logic       sfr_wr,             // Byte write strobe
  input  wire logic [7:0] sfr_wdata,          // Byte write data
  input  wire logic       sfr_bit_wr,         // Single-bit write strobe
  input  wire logic [2:0] sfr_bit_idx,        // Bit number for a bit write
  input  wire logic       sfr_bit_val,        // Value for a bit write
  output logic      [7:0] sfr_rdata,          // Read data, one cycle after address
  input  wire logic       count_pin_zero,     // Timer 0 event input
  input  wire logic       count_pin_one,      // Timer 1 event input
  input  wire logic       gate_pin_zero,      // Timer 0 gating input
  input  wire logic       gate_pin_one,       // Timer 1 gating input
  input  wire logic       vector_ack_zero,    // Core vectors to timer 0 handler
  input  wire logic       vector_ack_one,     // Core vectors to timer 1 handler
  output logic            overflow_flag_zero, // Timer 0 overflow request
  output logic            overflow_flag_one   // Timer 1 overflow request
);

  // ==========================================================
  // Registers
  logic [3:0] phase_r;     // Position within the machine cycle
  logic [7:0] mode_cfg_r;  // Mode register
  logic       run_zero_r;  // Timer 0 run bit
  logic       run_one_r;   // Timer 1 run bit
  logic       ovf_zero_r;  // Timer 0 overflow flag
  logic       ovf_one_r;   // Timer 1 overflow flag
  logic [7:0] low0_r;      // Timer 0 low byte
  logic [7:0] high0_r;     // Timer 0 high byte
  logic [7:0] low1_r;      // Timer 1 low byte
  logic [7:0] high1_r;     // Timer 1 high byte
  logic [7:0] rdata_r;     // Registered read data

  // ==========================================================
  // Count step shared by both timers
  // Returns overflow, high byte and low byte after one count
  function automatic logic [16:0] count_step(input logic [1:0] mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
    logic [16:0] res;
    logic [16:0] wide;
    res  = {1'b0, hi, lo};
    wide = {1'b0, hi, lo} + 17'h00001;
    case (timer_pair_pkg::mode_t'(mode))
      timer_pair_pkg::MODE_13BIT: begin
        // Upper three low bits are left alone; software ignores them
        res[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == timer_pair_pkg::PRESCALE_FULL) begin
          res[15:8] = hi + 8'h01;
          res[16]   = (hi == 8'hff);
        end
      end
      timer_pair_pkg::MODE_16BIT: begin
        res = wide;
      end
      timer_pair_pkg::MODE_RELOAD: begin
        if (lo == 8'hff) begin
          res[7:0] = hi;
          res[16]  = 1'b1;
        end else begin
          res[7:0] = lo + 8'h01;
        end
      end
      default: begin
        // Split mode: low byte alone, high byte handled by the caller
        res[7:0] = lo + 8'h01;
        res[16]  = (lo == 8'hff);
      end
    endcase
    return res;
  endfunction

  // ==========================================================
  // Machine cycle sequencer
  logic tick;      // Update phase, once per machine cycle
  logic smp_tick;  // Sample phase, once per machine cycle

  // Twelve core clocks make one machine cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 4'h0;
    end else if (phase_r == timer_pair_pkg::PHASES_PER_CYCLE - 4'h1) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 4'h1;
    end
  end

  assign tick     = (phase_r == timer_pair_pkg::UPDATE_PHASE);
  assign smp_tick = (phase_r == timer_pair_pkg::SAMPLE_PHASE);

  // ==========================================================
  // Pin sampling
  // Pins in order: count 0, count 1, gate 0, gate 1
  logic [3:0] pins;       // Raw pins
  logic [3:0] pin_level;  // Filtered levels
  logic [3:0] pin_fall;   // Falls seen in the last sample pair

  assign pins = {gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      pin_edge_sampler u_smp (
        .clk       (clk),
        .rst       (rst),
        .pin       (pins[gi]),
        .sample_en (smp_tick),
        .level     (pin_level[gi]),
        .edge_seen (pin_fall[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Mode decode
  logic [1:0] mode0;   // Timer 0 mode field
  logic [1:0] mode1;   // Timer 1 mode field
  logic       gate0;   // Timer 0 gating
  logic       gate1;   // Timer 1 gating
  logic       ct0;     // Timer 0 counts pin falls
  logic       ct1;     // Timer 1 counts pin falls
  logic       split0;  // Timer 0 in split mode

  assign mode0  = mode_cfg_r[timer_pair_pkg::POS_MODE_ZERO +: 2];
  assign mode1  = mode_cfg_r[timer_pair_pkg::POS_MODE_ONE +: 2];
  assign gate0  = mode_cfg_r[timer_pair_pkg::BIT_GATE_ZERO];
  assign gate1  = mode_cfg_r[timer_pair_pkg::BIT_GATE_ONE];
  assign ct0    = mode_cfg_r[timer_pair_pkg::BIT_CT_ZERO];
  assign ct1    = mode_cfg_r[timer_pair_pkg::BIT_CT_ONE];
  assign split0 = (mode0 == 2'(timer_pair_pkg::MODE_SPLIT));

  // ==========================================================
  // Count enables
  logic en0;    // Timer 0 low path may count
  logic en1;    // Timer 1 may count
  logic inc0;   // Timer 0 counts this cycle
  logic inc1;   // Timer 1 counts this cycle
  logic inc_h0; // Split high byte of timer 0 counts this cycle

  // Gate pin only matters when gating is on
  assign en0 = run_zero_r & (~gate0 | pin_level[2]);
  // With timer 0 split, its high byte owns the run bit of timer 1
  assign en1 = (split0 ? 1'b1 : run_one_r) & (~gate1 | pin_level[3])
             & (mode1 != 2'(timer_pair_pkg::MODE_SPLIT));
  // Pin falls are consumed at the update phase after detection
  assign inc0 = tick & en0 & (ct0 ? pin_fall[0] : 1'b1);
  assign inc1 = tick & en1 & (ct1 ? pin_fall[1] : 1'b1);
  // Split high byte counts machine cycles only
  assign inc_h0 = tick & split0 & run_one_r;

  // ==========================================================
  // Next count values
  logic [16:0] step0;     // Timer 0 step result
  logic [16:0] step1;     // Timer 1 step result
  logic        ovf0_evt;  // Timer 0 overflow this cycle
  logic        ovf1_evt;  // Timer 1 flag source this cycle
  logic        ovf_h0;    // Split high byte wraps

  assign step0    = count_step(mode0, low0_r, high0_r);
  assign step1    = count_step(mode1, low1_r, high1_r);
  assign ovf_h0   = inc_h0 & (high0_r == 8'hff);
  assign ovf0_evt = inc0 & step0[16];
  // While timer 0 is split, the timer 1 flag comes from its high byte, not from timer 1
  assign ovf1_evt = split0 ? ovf_h0 : (inc1 & step1[16]);

  // ==========================================================
  // Register writes
  logic wr_ctrl;    // Byte write to the control register
  logic bit_ctrl;   // Bit write to the control register
  logic [7:0] ctrl_now;  // Present control register image
  logic [7:0] ctrl_wv;   // Control register after a write

  assign wr_ctrl  = sfr_wr & (sfr_addr == timer_pair_pkg::ADDR_RUN_OVF_CTRL);
  assign bit_ctrl = sfr_bit_wr & (sfr_addr == timer_pair_pkg::ADDR_RUN_OVF_CTRL);

  // External interrupt bits live elsewhere and read back as zero
  always_comb begin
    ctrl_now = 8'h00;
    ctrl_now[timer_pair_pkg::BIT_OVF_ONE]  = ovf_one_r;
    ctrl_now[timer_pair_pkg::BIT_RUN_ONE]  = run_one_r;
    ctrl_now[timer_pair_pkg::BIT_OVF_ZERO] = ovf_zero_r;
    ctrl_now[timer_pair_pkg::BIT_RUN_ZERO] = run_zero_r;
    ctrl_wv = ctrl_now;
    if (wr_ctrl) begin
      ctrl_wv = sfr_wdata;
    end else if (bit_ctrl) begin
      ctrl_wv[sfr_bit_idx] = sfr_bit_val;
    end
  end

  // Mode register, not bit addressable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_cfg_r <= timer_pair_pkg::RST_MODE_CFG;
    end else if (sfr_wr && sfr_addr == timer_pair_pkg::ADDR_MODE_CFG) begin
      mode_cfg_r <= sfr_wdata;
    end
  end

  // Run bits: only software changes them; counts are never touched here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_zero_r <= 1'b0;
      run_one_r  <= 1'b0;
    end else begin
      run_zero_r <= ctrl_wv[timer_pair_pkg::BIT_RUN_ZERO];
      run_one_r  <= ctrl_wv[timer_pair_pkg::BIT_RUN_ONE];
    end
  end

  // Overflow flags: a hardware set wins over any clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_zero_r <= 1'b0;
      ovf_one_r  <= 1'b0;
    end else begin
      ovf_zero_r <= ovf0_evt | (ctrl_wv[timer_pair_pkg::BIT_OVF_ZERO]
                    & ~(vector_ack_zero & ~(wr_ctrl | bit_ctrl)));
      ovf_one_r  <= ovf1_evt | (ctrl_wv[timer_pair_pkg::BIT_OVF_ONE]
                    & ~(vector_ack_one & ~(wr_ctrl | bit_ctrl)));
    end
  end

  // ==========================================================
  // Count registers
  // A software write to a byte takes priority over the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low0_r  <= timer_pair_pkg::RST_COUNT;
      high0_r <= timer_pair_pkg::RST_COUNT;
    end else begin
      if (sfr_wr && sfr_addr == timer_pair_pkg::ADDR_LOW_ZERO) begin
        low0_r <= sfr_wdata;
      end else if (inc0) begin
        low0_r <= step0[7:0];
      end
      if (sfr_wr && sfr_addr == timer_pair_pkg::ADDR_HIGH_ZERO) begin
        high0_r <= sfr_wdata;
      end else if (split0) begin
        if (inc_h0) begin
          high0_r <= high0_r + 8'h01;
        end
      end else if (inc0) begin
        high0_r <= step0[15:8];
      end
    end
  end

  // Timer 1 bytes; split mode of its own leaves them frozen via en1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low1_r  <= timer_pair_pkg::RST_COUNT;
      high1_r <= timer_pair_pkg::RST_COUNT;
    end else begin
      if (sfr_wr && sfr_addr == timer_pair_pkg::ADDR_LOW_ONE) begin
        low1_r <= sfr_wdata;
      end else if (inc1) begin
        low1_r <= step1[7:0];
      end
      if (sfr_wr && sfr_addr == timer_pair_pkg::ADDR_HIGH_ONE) begin
        high1_r <= sfr_wdata;
      end else if (inc1) begin
        high1_r <= step1[15:8];
      end
    end
  end

  // ==========================================================
  // Read path
  // Unmapped addresses read zero so other blocks can share the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      case (sfr_addr)
        timer_pair_pkg::ADDR_RUN_OVF_CTRL: rdata_r <= ctrl_now;
        timer_pair_pkg::ADDR_MODE_CFG:     rdata_r <= mode_cfg_r;
        timer_pair_pkg::ADDR_LOW_ZERO:     rdata_r <= low0_r;
        timer_pair_pkg::ADDR_LOW_ONE:      rdata_r <= low1_r;
        timer_pair_pkg::ADDR_HIGH_ZERO:    rdata_r <= high0_r;
        timer_pair_pkg::ADDR_HIGH_ONE:     rdata_r <= high1_r;
        default:                           rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata          = rdata_r;
  assign overflow_flag_zero = ovf_zero_r;
  assign overflow_flag_one  = ovf_one_r;

  // ==========================================================
  // Checks
  logic wr_any;  // Any register write this cycle
  assign wr_any = sfr_wr | sfr_bit_wr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_tick_phase: assert property (
    (!$past(sfr_wr) && $changed(low0_r)) |-> ($past(phase_r) == timer_pair_pkg::UPDATE_PHASE))
    else $error("timer 0 low byte moved outside the update phase");

  chk_timer_rate: assert property (
    (tick && en0 && !ct0 && mode0 == 2'h1 && !wr_any)
      |=> (low0_r == $past(low0_r) + 8'h01) ##1 $stable(low0_r) [*8])
    else $error("timer 0 did not count once per machine cycle");

  chk_sample_phase: assert property (
    $changed(pin_fall[0]) |-> ($past(phase_r) == timer_pair_pkg::SAMPLE_PHASE))
    else $error("pin sample taken outside the sample phase");

  chk_count_edge: assert property (
    (ct0 && en0 && mode0 == 2'h1 && tick && pin_fall[0] && !wr_any)
      |=> (low0_r == $past(low0_r) + 8'h01))
    else $error("detected fall not counted at the update phase");

  chk_no_edge_hold: assert property (
    (ct0 && tick && !pin_fall[0] && !wr_any) |=> $stable(low0_r))
    else $error("counter moved without a pin fall");

  chk_gate_zero: assert property (
    (gate0 && !pin_level[2] && !wr_any) |=> $stable(low0_r))
    else $error("timer 0 counted while its gate pin was low");

  chk_gate_one: assert property (
    (gate1 && !pin_level[3] && !wr_any) |=> $stable({high1_r, low1_r}))
    else $error("timer 1 counted while its gate pin was low");

  chk_mode3_hold: assert property (
    (mode1 == 2'h3 && !wr_any) |=> $stable({high1_r, low1_r}))
    else $error("timer 1 moved while stopped");

  chk_reload_path: assert property (
    (mode0 == 2'h2 && inc0 && low0_r == 8'hff && !wr_any)
      |=> (low0_r == $past(high0_r)) && $stable(high0_r) && ovf_zero_r)
    else $error("reload did not copy the high byte");

  chk_ovf_flag: assert property (
    (ovf1_evt || ovf0_evt) |=> &({ovf_one_r, ovf_zero_r} | ~$past({ovf1_evt, ovf0_evt})))
    else $error("overflow did not raise its flag");

  cov_reload: cover property (mode0 == 2'h2 && inc0 && low0_r == 8'hff);
  cov_count_edge: cover property (ct1 && inc1);
  cov_split_high: cover property (split0 && ovf_h0);
  cov_prescale: cover property (mode0 == 2'h0 && ovf0_evt);

endmodule

// ==== test/event_pin_source.sv ====
// Far-side model of one timer's event pin and gating pin
`timescale 1ns/100ps

module event_pin_source #(
  parameter int HOLD = 14  // Clocks each level stands, above one machine cycle
) (
  input  wire logic clk,       // Core clock
  input  wire logic fire,      // One fall-and-rise pulse per sampled high
  input  wire logic gate_lvl,  // Level wanted on the gating pin
  output logic      count_pin, // Event pin, idles high, driven by the process below
  output logic      gate_pin   // Gating pin
);
  // ==========================================================
  // Gating pin follows the bench's wish directly
  assign gate_pin = gate_lvl;

  // ==========================================================
  // Each level stands a full machine cycle so that it is sampled
  // One process owns the pin, so it idles high from time zero
  initial begin
    count_pin = 1'b1;
    forever begin
      @(posedge clk);
      if (fire) begin
        count_pin <= 1'b0;
        repeat (HOLD) @(posedge clk);
        count_pin <= 1'b1;
        repeat (HOLD) @(posedge clk);
      end
    end
  end
endmodule

// ==== test/timer_pair_tb_top.sv ====
// Self-checking bench for the dual timer/counter unit
`timescale 1ns/100ps

module timer_pair_tb_top;
  // ==========================================================
  // Short names for the mapped addresses
  localparam logic [7:0] AC = timer_pair_pkg::ADDR_RUN_OVF_CTRL;
  localparam logic [7:0] AM = timer_pair_pkg::ADDR_MODE_CFG;
  localparam logic [7:0] L0 = timer_pair_pkg::ADDR_LOW_ZERO;
  localparam logic [7:0] L1 = timer_pair_pkg::ADDR_LOW_ONE;
  localparam logic [7:0] H0 = timer_pair_pkg::ADDR_HIGH_ZERO;
  localparam logic [7:0] H1 = timer_pair_pkg::ADDR_HIGH_ONE;

  logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [2:0] sfr_bit_idx = 3'h0;
  logic cp0, cp1, gp0, gp1, ovf0, ovf1;
  logic ack0 = 1'b0, ack1 = 1'b0, fire0 = 1'b0, fire1 = 1'b0, g0 = 1'b0, g1 = 1'b0;
  int error_cnt = 0, samples_checked = 0;

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  error_cnt++; $display("mismatch %s exp %h got %h", nm, exp, got); end end

  // 50 MHz core clock
  always #10 clk = ~clk;

  timer_pair u_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .count_pin_zero(cp0),
    .count_pin_one(cp1), .gate_pin_zero(gp0), .gate_pin_one(gp1),
    .vector_ack_zero(ack0), .vector_ack_one(ack1),
    .overflow_flag_zero(ovf0), .overflow_flag_one(ovf1));
  event_pin_source u_src0 (.clk(clk), .fire(fire0), .gate_lvl(g0), .count_pin(cp0),
    .gate_pin(gp0));
  event_pin_source u_src1 (.clk(clk), .fire(fire1), .gate_lvl(g1), .count_pin(cp1),
    .gate_pin(gp1));

  // ==========================================================
  // Register access tasks, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1'b1;
    @(posedge clk) sfr_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bw(input logic [2:0] i, input logic v);
    sfr_addr <= AC; sfr_bit_idx <= i; sfr_bit_val <= v; sfr_bit_wr <= 1'b1;
    @(posedge clk) sfr_bit_wr <= 1'b0;
    @(posedge clk);
  endtask
  // Read data lands one edge after the address is taken
  task automatic rdr(input logic [7:0] a, lo, hi, input string nm);
    logic [7:0] v;
    sfr_addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1 v = sfr_rdata;
    `CHK(nm, lo, ((v >= lo && v <= hi) ? lo : v))
    @(posedge clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One fall on a pin; waits out both held levels
  task automatic pulse(input logic one);
    if (one) fire1 <= 1'b1; else fire0 <= 1'b1;
    @(posedge clk) begin fire1 <= 1'b0; fire0 <= 1'b0; end
    cyc(32);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the fewer than one thousand clocks the tests take
  initial begin
    cyc(20000);
    error_cnt++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    cyc(12);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and an unmapped place
    rdr(AC, 8'h00, 8'h00, "ctrl_rst");
    rdr(AM, 8'h00, 8'h00, "mode_rst");
    rdr(H1, 8'h00, 8'h00, "high1_rst");
    rdr(8'h90, 8'h00, 8'h00, "unmapped");
    wr(AM, 8'ha6);
    rdr(AM, 8'ha6, 8'ha6, "mode_rw");
    // Timer 0, 16 bit, rolls over and raises its flag
    wr(AM, 8'h01); wr(L0, 8'hfe); wr(H0, 8'hff);
    bw(3'h4, 1'b1);
    cyc(30);
    `CHK("ovf0", 1'b1, ovf0)
    rdr(AC, 8'h30, 8'h30, "ctrl_flag");
    ack0 <= 1'b1;
    @(posedge clk) ack0 <= 1'b0;
    cyc(2);
    `CHK("ovf0_ack", 1'b0, ovf0)
    // Count rate of the machine-cycle clock, count kept over run
    wr(AC, 8'h00); wr(L0, 8'h05);
    bw(3'h4, 1'b1);
    cyc(118);
    bw(3'h4, 1'b0);
    rdr(L0, 8'h0e, 8'h10, "rate");
    // Auto-reload mode
    wr(AM, 8'h02); wr(H0, 8'h80); wr(L0, 8'hfe);
    bw(3'h4, 1'b1);
    cyc(34);
    wr(AC, 8'h00);
    rdr(L0, 8'h80, 8'h82, "reload");
    rdr(H0, 8'h80, 8'h80, "reload_high");
    // 13-bit mode, upper low bits kept
    wr(AM, 8'h00); wr(L0, 8'hff); wr(H0, 8'h00);
    bw(3'h4, 1'b1);
    cyc(8);
    wr(AC, 8'h00);
    rdr(H0, 8'h01, 8'h01, "pre_high");
    rdr(L0, 8'he0, 8'he1, "pre_low");
    // Gated timer 0 holds while its gating pin is low
    wr(AM, 8'h09); wr(L0, 8'h00);
    bw(3'h4, 1'b1);
    cyc(50);
    rdr(L0, 8'h00, 8'h00, "gate0_low");
    g0 <= 1'b1;
    cyc(50);
    rdr(L0, 8'h03, 8'h06, "gate0_high");
    // Timer 1 counts pin falls, then only while gated high
    wr(AC, 8'h00); wr(AM, 8'h50); wr(L1, 8'h00);
    bw(3'h6, 1'b1);
    cyc(30);
    repeat (3) pulse(1'b1);
    rdr(L1, 8'h03, 8'h03, "events");
    wr(AM, 8'hd0);
    repeat (2) pulse(1'b1);
    rdr(L1, 8'h03, 8'h03, "gated_events");
    g1 <= 1'b1;
    cyc(20);
    pulse(1'b1);
    rdr(L1, 8'h04, 8'h04, "open_events");
    // Timer 0 counts falls on its own pin
    wr(AM, 8'h05); wr(L0, 8'h00);
    bw(3'h4, 1'b1);
    cyc(30);
    repeat (2) pulse(1'b0);
    rdr(L0, 8'h02, 8'h02, "events0");
    // Timer 1 stops in mode 11
    wr(AM, 8'h30); wr(L1, 8'h42);
    cyc(50);
    rdr(L1, 8'h42, 8'h42, "t1_stop");
    // Timer 0 split: high byte runs on timer 1's run bit and flag
    wr(AC, 8'h40); wr(AM, 8'h03); wr(L0, 8'h00); wr(H0, 8'hff);
    cyc(26);
    `CHK("split_ovf1", 1'b1, ovf1)
    rdr(L0, 8'h00, 8'h00, "split_low");
    ack1 <= 1'b1;
    @(posedge clk) ack1 <= 1'b0;
    cyc(2);
    `CHK("ovf1_ack", 1'b0, ovf1)
    final_report();
  end
endmodule
